// *** hw/acs_consts.vh ***
// constants for the conversion sequencer
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ACS_OFF_RES_HIGH 8'h00
`define ACS_OFF_RES_LOW 8'h04
`define ACS_OFF_CTL_ZERO 8'h08
`define ACS_OFF_CTL_ONE 8'h0C
`define ACS_OFF_CTL_TWO 8'h10
`define ACS_OFF_FLAG 8'h14
`define ACS_OFF_ENABLE 8'h18
`define ACS_OFF_PRIORITY 8'h1C
// ----------------------------------------
// field positions
// ----------------------------------------
`define ACS_ON_BIT 0
`define ACS_GO_BIT 1
`define ACS_CHS_LO 2
`define ACS_CHS_HI 5
`define ACS_CFG_LO 0
`define ACS_CFG_HI 3
`define ACS_REF_LO 4
`define ACS_REF_HI 5
`define ACS_CS_LO 0
`define ACS_CS_HI 2
`define ACS_AQ_LO 3
`define ACS_AQ_HI 5
`define ACS_JUST_BIT 7
`define ACS_DONE_BIT 6
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define ACS_RST_CTL 8'h00
`define ACS_RST_PRIO 1'b1
`define ACS_TRIG_MODE 4'hB
`define ACS_SAR_FIRST 10'h200
// ----------------------------------------
// timing counts
// ----------------------------------------
`define ACS_INSTR_CLKS 3'h4
`define ACS_CONV_LAST 4'hA
`define ACS_RECOVER_TADS 5'h02
`define ACS_CNT_W 6
`endif

// *** hw/acs_sequencer.v ***
// conversion sequencer: clock select, acquisition, SAR sequencing, registers
//
// Summary of operation
// RQ1: clock select picks 2..64 oscillator periods or RC
// RQ2: software keeps bit period above minimum
// RQ3: RC bit period comes from internal oscillator
// RQ4: analog pins read zero on port reads
// RQ5: channel and direction bits never gate sequencing
// RQ6: zero acquisition: start after one instruction cycle
// RQ7: acquisition code 010 samples four bit periods
// RQ8: clearing go/done aborts and discards conversion
// RQ9: abort leaves result registers unchanged
// RQ10: two bit periods wait, then sampling resumes
// RQ11: software enables converter before setting go
// RQ12: mode 1011 special event starts conversion
// RQ13: special event clears the period timer
// RQ14: converter off ignores event, timer still cleared
// RQ15: software selects channel, acquires before trigger
// RQ16: control zero: channel, go, on; resets zero
// RQ17: control one: reference and port config; resets zero
// RQ18: control two: justify and clock select
// RQ19: done flag, enable, priority at bit six
// RQ20: result registers hold through resets
// RQ21: completion clears go, flags, loads, resamples
// RQ22: conversion takes eleven bit periods
// RQ23: acquisition field bits five to three
// RQ24: reset turns converter off, aborts conversion
// RQ25: justify bit selects right or left placement
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`include "acs_consts.vh"

module acs_sequencer (
  // clock and reset
  input wire clk,
  input wire resetn,
  // apb slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // analog core
  input wire rc_tick,
  input wire core_cmp_hi,
  output wire core_sampling,
  output wire core_converting,
  output wire [9:0] core_trial_code,
  output wire [3:0] core_channel,
  output wire [1:0] core_reference_config,
  // compare unit
  input wire [3:0] compare_unit_mode,
  input wire special_event,
  output reg period_timer_clear,
  // port pins
  input wire [15:0] port_pins_in,
  output reg [15:0] port_read_data,
  // interrupt controller
  output wire conv_done_flag,
  output wire conv_done_enable,
  output wire conv_done_priority
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_SAMPLE = 3'h0;
  localparam ST_DELAY = 3'h1;
  localparam ST_ACQ = 3'h2;
  localparam ST_CONV = 3'h3;
  localparam ST_RECOVER = 3'h4;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // bit period in oscillator periods, minus one
  function [5:0] tad_div;
    input [2:0] sel;
    begin
      case (sel[1:0])
        2'h0: tad_div = sel[2] ? 6'h03 : 6'h01;
        2'h1: tad_div = sel[2] ? 6'h0F : 6'h07;
        2'h2: tad_div = sel[2] ? 6'h3F : 6'h1F;
        default: tad_div = 6'h00;
      endcase
    end
  endfunction

  // acquisition length in bit periods
  function [4:0] acq_tads;
    input [2:0] code;
    begin
      case (code)
        3'h1: acq_tads = 5'h02;
        3'h2: acq_tads = 5'h04;
        3'h3: acq_tads = 5'h06;
        3'h4: acq_tads = 5'h08;
        3'h5: acq_tads = 5'h0C;
        3'h6: acq_tads = 5'h10;
        3'h7: acq_tads = 5'h14;
        default: acq_tads = 5'h00;
      endcase
    end
  endfunction

  // pins set to analog by the port configuration
  function [15:0] analog_mask;
    input [3:0] cfg;
    integer i;
    begin
      analog_mask = 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        if (i < 16 - cfg)
          analog_mask[i] = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [3:0] chan_q;
  reg go_q;
  reg on_q;
  reg [1:0] ref_q;
  reg [3:0] cfg_q;
  reg just_q;
  reg [2:0] acq_q;
  reg [2:0] cs_q;
  reg flag_q;
  reg en_q;
  reg prio_q;
  reg [7:0] res_hi_q;
  reg [7:0] res_lo_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [5:0] div_q;
  reg [4:0] cnt_q;
  reg [2:0] icnt_q;
  reg [9:0] sar_q;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire mapped = (paddr == `ACS_OFF_RES_HIGH) | (paddr == `ACS_OFF_RES_LOW) |
                (paddr == `ACS_OFF_CTL_ZERO) | (paddr == `ACS_OFF_CTL_ONE) |
                (paddr == `ACS_OFF_CTL_TWO) | (paddr == `ACS_OFF_FLAG) |
                (paddr == `ACS_OFF_ENABLE) | (paddr == `ACS_OFF_PRIORITY);
  wire wr_res_hi = wr & (paddr == `ACS_OFF_RES_HIGH);
  wire wr_res_lo = wr & (paddr == `ACS_OFF_RES_LOW);
  wire wr_ctl0 = wr & (paddr == `ACS_OFF_CTL_ZERO);
  wire wr_ctl1 = wr & (paddr == `ACS_OFF_CTL_ONE);
  wire wr_ctl2 = wr & (paddr == `ACS_OFF_CTL_TWO);
  wire wr_flag = wr & (paddr == `ACS_OFF_FLAG);
  wire wr_en = wr & (paddr == `ACS_OFF_ENABLE);
  wire wr_prio = wr & (paddr == `ACS_OFF_PRIORITY);

  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `ACS_OFF_RES_HIGH: prdata[7:0] = res_hi_q;
      `ACS_OFF_RES_LOW: prdata[7:0] = res_lo_q;
      `ACS_OFF_CTL_ZERO: prdata[7:0] = {2'h0, chan_q, go_q, on_q};
      `ACS_OFF_CTL_ONE: prdata[7:0] = {2'h0, ref_q, cfg_q};
      `ACS_OFF_CTL_TWO: prdata[7:0] = {just_q, 1'b0, acq_q, cs_q};
      `ACS_OFF_FLAG: prdata[`ACS_DONE_BIT] = flag_q;
      `ACS_OFF_ENABLE: prdata[`ACS_DONE_BIT] = en_q;
      `ACS_OFF_PRIORITY: prdata[`ACS_DONE_BIT] = prio_q;
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // trigger and sequencing events
  // ----------------------------------------
  wire trig_evt = special_event & (compare_unit_mode == `ACS_TRIG_MODE);
  wire trig_go = trig_evt & on_q; // see RQ12 see RQ14
  // go is only honoured once the converter was already on
  wire sw_go = wr_ctl0 & pwdata[`ACS_GO_BIT] & on_q; // see RQ11
  wire sw_stop = wr_ctl0 & ~pwdata[`ACS_GO_BIT];
  wire busy = (state_q == ST_DELAY) | (state_q == ST_ACQ) | (state_q == ST_CONV);
  // converter switched off also aborts
  wire turn_off = wr_ctl0 & ~pwdata[`ACS_ON_BIT];
  wire abort = busy & ~trig_go & (sw_stop | turn_off); // see RQ8

  // bit period tick; divider restarts on every state change
  wire rc_sel = (cs_q[1:0] == 2'h3); // see RQ3
  wire div_tick = (div_q == tad_div(cs_q)); // see RQ1
  wire tad_tick = rc_sel ? rc_tick : div_tick;
  wire conv_done = (state_q == ST_CONV) & tad_tick & (cnt_q[3:0] == `ACS_CONV_LAST);
  // SAR decision applied to the trial code
  wire [9:0] resolved = core_cmp_hi ? sar_q :
                        (sar_q & ~(10'h001 << (4'h9 - (cnt_q[3:0] - 4'h1))));
  wire [9:0] next_trial = resolved | ((10'h001 << (4'h9 - cnt_q[3:0])) &
                          {10{cnt_q[3:0] != `ACS_CONV_LAST}});

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin // see RQ24
      chan_q <= 4'h0;
      on_q <= 1'b0;
      ref_q <= 2'h0;
      cfg_q <= 4'h0; // see RQ17
      just_q <= 1'b0;
      acq_q <= 3'h0; // see RQ23
      cs_q <= 3'h0; // see RQ18
      en_q <= 1'b0;
      prio_q <= `ACS_RST_PRIO; // see RQ19
    end else begin
      if (wr_ctl0) begin // see RQ16
        chan_q <= pwdata[`ACS_CHS_HI:`ACS_CHS_LO];
        on_q <= pwdata[`ACS_ON_BIT];
      end
      if (wr_ctl1) begin
        ref_q <= pwdata[`ACS_REF_HI:`ACS_REF_LO];
        cfg_q <= pwdata[`ACS_CFG_HI:`ACS_CFG_LO];
      end
      if (wr_ctl2) begin
        just_q <= pwdata[`ACS_JUST_BIT];
        acq_q <= pwdata[`ACS_AQ_HI:`ACS_AQ_LO];
        cs_q <= pwdata[`ACS_CS_HI:`ACS_CS_LO];
      end
      if (wr_en)
        en_q <= pwdata[`ACS_DONE_BIT];
      if (wr_prio)
        prio_q <= pwdata[`ACS_DONE_BIT];
    end
  end

  // ----------------------------------------
  // go/done and done flag
  // ----------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      go_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      // trigger set wins over software clear
      if (trig_go | sw_go)
        go_q <= 1'b1;
      else if (conv_done) // see RQ21
        go_q <= 1'b0;
      else if (wr_ctl0)
        go_q <= 1'b0; // clear, or go refused while converter was off
      // completion set wins over software clear
      if (conv_done)
        flag_q <= 1'b1; // see RQ19
      else if (wr_flag)
        flag_q <= pwdata[`ACS_DONE_BIT];
    end
  end

  // ----------------------------------------
  // result registers: no reset at all
  // ----------------------------------------
  always @(posedge clk) begin // see RQ20
    if (conv_done) begin // see RQ9 see RQ25
      res_hi_q <= just_q ? {6'h00, next_trial[9:8]} : next_trial[9:2];
      res_lo_q <= just_q ? next_trial[7:0] : {next_trial[1:0], 6'h00};
    end else begin
      if (wr_res_hi)
        res_hi_q <= pwdata[7:0];
      if (wr_res_lo)
        res_lo_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // sequencer state machine
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_SAMPLE: begin
        // channel and pin direction take no part here
        if (go_q & on_q) // see RQ5
          state_d = (acq_q == 3'h0) ? ST_DELAY : ST_ACQ;
      end
      ST_DELAY: begin
        if (icnt_q == `ACS_INSTR_CLKS - 3'h1) // see RQ6
          state_d = ST_CONV;
      end
      ST_ACQ: begin
        if (tad_tick & (cnt_q == acq_tads(acq_q) - 5'h01)) // see RQ7
          state_d = ST_CONV;
      end
      ST_CONV: begin
        if (conv_done) // see RQ22
          state_d = ST_RECOVER;
      end
      ST_RECOVER: begin
        if (tad_tick & (cnt_q == `ACS_RECOVER_TADS - 5'h01)) // see RQ10
          state_d = ST_SAMPLE;
      end
      default: state_d = ST_SAMPLE;
    endcase
    if (abort)
      state_d = ST_RECOVER;
  end

  always @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_SAMPLE;
      div_q <= 6'h00;
      cnt_q <= 5'h00;
      icnt_q <= 3'h0;
      sar_q <= 10'h000;
    end else begin
      state_q <= state_d;
      if ((state_d != state_q) | div_tick)
        div_q <= 6'h00;
      else
        div_q <= div_q + 6'h01;
      if (state_d != state_q)
        cnt_q <= 5'h00;
      else if (tad_tick)
        cnt_q <= cnt_q + 5'h01;
      icnt_q <= (state_q == ST_DELAY) ? icnt_q + 3'h1 : 3'h0;
      // partial code is dropped on abort
      if (state_q != ST_CONV)
        sar_q <= `ACS_SAR_FIRST;
      else if (tad_tick & (cnt_q != 5'h00) & ~conv_done)
        sar_q <= next_trial;
    end
  end

  // ----------------------------------------
  // analog core and pin side
  // ----------------------------------------
  assign core_sampling = on_q & ~(state_q == ST_CONV) & ~(state_q == ST_RECOVER);
  assign core_converting = (state_q == ST_CONV);
  assign core_trial_code = sar_q;
  assign core_channel = chan_q;
  assign core_reference_config = ref_q;
  assign conv_done_flag = flag_q;
  assign conv_done_enable = en_q;
  assign conv_done_priority = prio_q;

  always @(posedge clk) begin
    if (!resetn) begin
      period_timer_clear <= 1'b0;
      port_read_data <= 16'h0000;
    end else begin
      period_timer_clear <= trig_evt; // see RQ13 see RQ14
      port_read_data <= port_pins_in & ~analog_mask(cfg_q); // see RQ4
    end
  end

endmodule

// *** tb/acs_core_model.sv ***
// behavioural analog core: comparator and rc bit clock
module acs_core_model #(
  parameter int RC_DIV = 37
) (
  // clock
  input wire clk,
  // core side
  input wire [9:0] core_trial_code,
  input wire core_converting,
  input wire [9:0] level,
  output logic core_cmp_hi,
  output logic rc_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  always @(posedge clk) begin
    cnt <= (cnt == RC_DIV - 1) ? 0 : cnt + 1;
  end
  // one pulse per rc bit period
  assign rc_tick = (cnt == 0);
  // decision only valid while converting, else a changing pattern
  assign core_cmp_hi = core_converting ? (core_trial_code <= level) : cnt[0];
endmodule

// *** tb/acs_properties.sv ***
// assertion checker on the conversion sequencer ports
module acs_properties (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register bus
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pslverr,
  // core, compare unit, flag
  input wire core_sampling,
  input wire core_converting,
  input wire [3:0] compare_unit_mode,
  input wire special_event,
  input wire period_timer_clear,
  input wire conv_done_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  wire acc = psel && penable;
  wire trg = special_event && compare_unit_mode == 4'hB;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // checks
  // ----
  a_trig_clears_timer:
    assert property (trg |=> period_timer_clear) else $error("no timer clear");
  a_clear_has_cause:
    assert property (period_timer_clear |-> $past(trg)) else $error("stray timer clear");
  a_bad_addr_err:
    assert property (acc && paddr > 8'h1C |-> pslverr) else $error("no slave error");
  a_good_addr_ok:
    assert property (acc && paddr <= 8'h1C && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("false slave error");
  a_read_upper_zero:
    assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_done_after_conv:
    assert property ($rose(conv_done_flag) && !$past(acc && pwrite) |-> $past(core_converting))
    else $error("flag without conversion");
  a_samp_conv_excl:
    assert property (!(core_sampling && core_converting)) else $error("sample during conversion");
  a_recovery_gap:
    assert property ($fell(core_converting) |-> !core_sampling [*4]) else $error("short recovery");
  c_done: cover property ($rose(conv_done_flag));
  c_trig: cover property (trg && core_sampling);
  c_err: cover property (acc && pslverr);
endmodule
bind acs_sequencer acs_properties acs_properties_i (.clk, .resetn, .paddr, .psel, .penable,
  .pwrite, .prdata, .pslverr, .core_sampling, .core_converting, .compare_unit_mode,
  .special_event, .period_timer_clear, .conv_done_flag);

// *** tb/adc_conversion_sequencer_bench.sv ***
// self-checking bench for the conversion sequencer
module adc_conversion_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] c2; logic [9:0] lvl; int conv_bit_period;} row_t;
  row_t rows [7] = '{'{8'h80, 10'h3A5, 2}, '{8'h04, 10'h155, 4}, '{8'h81, 10'h000, 8},
    '{8'h15, 10'h3FF, 16}, '{8'h02, 10'h2AA, 32}, '{8'h86, 10'h001, 64}, '{8'h03, 10'h1C3, 0}};
  logic clk = 0;
  logic resetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic special_event = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] compare_unit_mode = 4'h0;
  logic [15:0] port_pins_in = 16'hFFFF;
  logic [9:0] level = 10'h000;
  logic [31:0] prdata, rd;
  logic [15:0] port_read_data, e;
  logic [9:0] core_trial_code;
  logic [3:0] core_channel;
  logic [1:0] core_reference_config;
  logic conv_done_enable, conv_done_priority;
  logic pready, pslverr, core_cmp_hi, rc_tick, core_sampling, core_converting;
  logic period_timer_clear, conv_done_flag, err;
  int fail_count = 0;
  int total_checks = 0;
  int m;
  always #2.5 clk = ~clk;
  acs_sequencer acs_sequencer_i (.clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .rc_tick, .core_cmp_hi, .core_sampling, .core_converting,
    .core_trial_code, .core_channel, .core_reference_config, .compare_unit_mode,
    .special_event, .period_timer_clear, .port_pins_in, .port_read_data, .conv_done_flag,
    .conv_done_enable, .conv_done_priority);
  acs_core_model acs_core_model_i (.clk, .core_trial_code, .core_converting, .level,
    .core_cmp_hi, .rc_tick);
  // ----
  // tasks
  // ----
  task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task apb(input bit w, input [7:0] a, input [7:0] d);
    int k;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    for (k = 0; pready !== 1'b1; k++) begin
      if (k > 20) begin
        fail_count++;
        results;
      end
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdc(input [7:0] a, input [31:0] x);
    apb(0, a, 8'h00);
    chk(rd, x);
  endtask
  function logic sig(int s);
    return s == 0 ? core_converting : s == 1 ? !core_converting : core_sampling;
  endfunction
  // counts edges until the chosen condition holds
  task till(input int s);
    #1;
    for (m = 0; sig(s) !== 1'b1; m++) begin
      if (m > 3000) begin
        fail_count++;
        results;
      end
      @(posedge clk);
      #1;
    end
  endtask
  task near(input int v, input int lo);
    chk(v >= lo && v <= lo + 2, 1);
  endtask
  task ev(input [3:0] md);
    @(posedge clk);
    compare_unit_mode <= md;
    special_event <= 1;
    @(posedge clk);
    special_event <= 0;
    #1;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1;
    rdc(8'h08, 0);
    rdc(8'h0C, 0);
    rdc(8'h10, 0);
    rdc(8'h1C, 32'h40);
    chk(conv_done_priority, 1);
    apb(1, 8'h08, 8'hFC);
    rdc(8'h08, 32'h3C);
    chk(core_channel, 4'hF);
    apb(1, 8'h10, 8'hFF);
    rdc(8'h10, 32'hBF);
    apb(1, 8'h18, 8'hFF);
    rdc(8'h18, 32'h40);
    chk(conv_done_enable, 1);
    rdc(8'h24, 0);
    chk(err, 1);
    apb(1, 8'h0C, 8'h3F);
    repeat (2) @(posedge clk);
    #1 chk(port_read_data, 16'hFFFE);
    rdc(8'h0C, 32'h3F);
    chk(core_reference_config, 2'h3);
    apb(1, 8'h0C, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk(port_read_data, 16'h0000);
    $display("registers and ports done");
    foreach (rows[i]) begin
      apb(1, 8'h10, rows[i].c2);
      apb(1, 8'h08, {4'(i), 2'b01});
      level <= rows[i].lvl;
      apb(1, 8'h08, {4'(i), 2'b11});
      till(0);
      if (rows[i].conv_bit_period > 0) near(m, rows[i].c2[4] ? 4 * rows[i].conv_bit_period : 4);
      till(1);
      if (rows[i].conv_bit_period > 0) near(m, 11 * rows[i].conv_bit_period);
      chk(conv_done_flag, 1);
      till(2);
      if (rows[i].conv_bit_period > 0) near(m, 2 * rows[i].conv_bit_period - 1);
      rdc(8'h08, {4'(i), 2'b01});
      e = rows[i].c2[7] ? {6'h0, rows[i].lvl} : {rows[i].lvl, 6'h0};
      rdc(8'h00, e[15:8]);
      rdc(8'h04, e[7:0]);
      apb(1, 8'h14, 8'h00);
      rdc(8'h14, 0);
      $display("row %0d done", i);
    end
    apb(1, 8'h08, 8'h00);
    apb(1, 8'h08, 8'h03);
    rdc(8'h08, 1);
    apb(1, 8'h10, 8'h06);
    level <= 10'h0F0;
    apb(1, 8'h08, 8'h03);
    till(0);
    apb(1, 8'h08, 8'h01);
    till(1);
    near(m, 0);
    chk(conv_done_flag, 0);
    till(2);
    near(m, 127);
    rdc(8'h00, e[15:8]);
    rdc(8'h04, e[7:0]);
    apb(1, 8'h00, 8'h5A);
    rdc(8'h00, 32'h5A);
    $display("abort done");
    apb(1, 8'h08, 8'h00);
    ev(4'hB);
    chk(period_timer_clear, 1);
    rdc(8'h08, 0);
    apb(1, 8'h08, 8'h01);
    apb(1, 8'h10, 8'h80);
    level <= 10'h2C1;
    ev(4'hA);
    chk(period_timer_clear, 0);
    ev(4'hB);
    chk(period_timer_clear, 1);
    till(0);
    chk(core_converting, 1);
    till(1);
    chk(conv_done_flag, 1);
    rdc(8'h00, 32'h02);
    rdc(8'h04, 32'hC1);
    $display("trigger done");
    apb(1, 8'h08, 8'h03);
    till(0);
    @(posedge clk);
    resetn <= 0;
    repeat (2) @(posedge clk);
    resetn <= 1;
    #1 chk(core_converting, 0);
    rdc(8'h08, 0);
    rdc(8'h00, 32'h02);
    $display("reset done");
    results;
  end
endmodule
